// file: verilog/htcr_defs.vh
`ifndef HTCR_DEFS_VH
`define HTCR_DEFS_VH

// Privilege levels on i_priv_level
`define HTCR_PL_USER       2'h0
`define HTCR_PL_KERNEL     2'h1
`define HTCR_PL_HYP        2'h2

// System register access encoding
`define HTCR_COPROC_SYS    4'hf
`define HTCR_COPROC_DBG    4'he
`define HTCR_OPC1_HYP      3'h4
`define HTCR_CRN_CFG       4'h1
`define HTCR_CRM_CFG       4'h1
`define HTCR_OPC2_MAIN     3'h0
`define HTCR_OPC2_DBGCTL   3'h1
`define HTCR_OPC2_EXTRA    3'h4

// Main configuration register fields
`define HTCR_MAIN_STAGE2   0
`define HTCR_MAIN_SETWAY   1
`define HTCR_MAIN_FIQMO    3
`define HTCR_MAIN_DEFCACHE 12
`define HTCR_MAIN_TRAPGEN  27
`define HTCR_MAIN_RESET    32'h00000000

// Extra configuration register fields
`define HTCR_EXTRA_MIXCOH  6
`define HTCR_EXTRA_RESET   32'h00000000

// Debug trap control register fields
`define HTCR_DBG_CNT_LSB   0
`define HTCR_DBG_CNT_MSB   4
`define HTCR_DBG_TDEBEXC   8
`define HTCR_DBG_TDBGACC   9
`define HTCR_DBG_TOSREGS   10
`define HTCR_DBG_TROMADR   11
`define HTCR_DBG_HCNTDIS   17
`define HTCR_DBG_EXTCDIS   21
`define HTCR_DBG_RESET     32'h00000000

// Trap classes of a guest debug register access
`define HTCR_DCLS_OTHER    2'h0
`define HTCR_DCLS_ROM      2'h1
`define HTCR_DCLS_OSPWR    2'h2

// Syndrome class codes
`define HTCR_SYN_NONE      2'h0
`define HTCR_SYN_CFGREG    2'h1
`define HTCR_SYN_DEBUG     2'h2
`define HTCR_SYN_DENIED    2'h3

`endif

// file: verilog/htcr_debug_trap.v
`timescale 1ns/1ns
`include "htcr_defs.vh"

module htcr_debug_trap (
  input  wire       i_guest_access,
  input  wire [1:0] i_priv_level,
  input  wire [1:0] i_dbg_class,
  input  wire       i_comms_trapped,
  input  wire       i_eff_rom,
  input  wire       i_eff_os,
  input  wire       i_eff_acc,
  input  wire       i_eff_exc,
  output wire       o_trap
);

  wire is_user;
  wire is_kernel;
  wire rom_hit;
  wire os_hit;
  wire acc_hit;

  assign is_user   = (i_priv_level == `HTCR_PL_USER);
  assign is_kernel = (i_priv_level == `HTCR_PL_KERNEL);

  // The comms-channel trap has priority, so the ROM, access and exception traps stand aside; the OS trap does not
  assign rom_hit = i_eff_rom && (i_dbg_class == `HTCR_DCLS_ROM) && !i_comms_trapped;
  assign os_hit  = i_eff_os && (i_dbg_class == `HTCR_DCLS_OSPWR) && is_kernel;
  assign acc_hit = (i_eff_acc || i_eff_exc) && (i_dbg_class == `HTCR_DCLS_OTHER)
                   && !i_comms_trapped;

  assign o_trap = i_guest_access && (is_user || is_kernel)
                  && (rom_hit || os_hit || acc_hit || (i_eff_exc && !i_comms_trapped));
endmodule

// file: verilog/htcr_counter_gate.v
`timescale 1ns/1ns
`include "htcr_defs.vh"

module htcr_counter_gate #(
  parameter NUM_COUNTERS = 31
) (
  input  wire [4:0]              i_el1_counter_count,
  input  wire                    i_hyp_counting_disable,
  input  wire                    i_ext_counter_disable,
  input  wire                    i_in_hyp,
  input  wire                    i_cycle_counter_disable_prohibited,
  input  wire                    i_hyp_noninv_debug_override,
  output wire [NUM_COUNTERS-1:0] o_count_enable,
  output wire                    o_cycle_count_enable,
  output wire [NUM_COUNTERS-1:0] o_ext_access_enable
);

  genvar g;
  generate
    for (g = 0; g < NUM_COUNTERS; g = g + 1) begin : gen_cnt
      wire guest_owned;
      assign guest_owned = (g < i_el1_counter_count);
      assign o_count_enable[g] = !(guest_owned && i_in_hyp && i_hyp_counting_disable);
      assign o_ext_access_enable[g] = guest_owned || !i_ext_counter_disable
                                      || i_hyp_noninv_debug_override;
    end
  endgenerate

  assign o_cycle_count_enable = !(i_in_hyp && i_hyp_counting_disable
                                  && i_cycle_counter_disable_prohibited);
endmodule

// file: verilog/htcr_regs.v
`timescale 1ns/1ns
`include "htcr_defs.vh"

module htcr_regs #(
  parameter         SETWAY_FIXED_ONE = 0,
  parameter         MIXCOH_RAZ       = 0,
  parameter         NUM_COUNTERS     = 31,
  parameter [4:0]   COUNT_RESET      = 5'h1f
) (
  input  wire                    i_clock,
  input  wire                    i_srst,
  input  wire                    i_warm_srst,
  input  wire                    i_sys_valid,
  input  wire                    i_sys_write,
  input  wire [3:0]              i_coproc,
  input  wire [2:0]              i_opc1,
  input  wire [3:0]              i_crn,
  input  wire [3:0]              i_crm,
  input  wire [2:0]              i_opc2,
  input  wire [31:0]             i_sys_wdata,
  input  wire [1:0]              i_priv_level,
  input  wire                    i_sysreg_trap_bit,
  input  wire [1:0]              i_dbg_class,
  input  wire                    i_comms_trapped,
  input  wire                    i_dcache_inval,
  input  wire                    i_dcache_setway,
  input  wire                    i_debug_exception,
  input  wire                    i_cycle_counter_disable_prohibited,
  input  wire                    i_hyp_noninv_debug_override,
  output reg  [31:0]             o_sys_rdata,
  output reg                     o_sys_done,
  output reg                     o_trap,
  output reg                     o_undef,
  output reg  [1:0]              o_syndrome_class,
  output reg  [19:0]             o_syndrome_info,
  output wire                    o_eff_fiq_mask_override,
  output wire                    o_eff_stage2_enable,
  output wire                    o_convert_to_clean_inval,
  output wire                    o_mixcoh_noncoherent,
  output wire                    o_route_debug_to_hyp,
  output wire [NUM_COUNTERS-1:0] o_count_enable,
  output wire                    o_cycle_count_enable,
  output wire [NUM_COUNTERS-1:0] o_ext_access_enable
);

  reg         fiq_mask_override;
  reg         setway_inval_override;
  reg         stage2_protect_enable;
  reg         default_cacheability;
  reg         trap_general_exceptions;
  reg         mismatched_cacheability_noncoherence;
  reg         ext_debug_hyp_counter_disable;
  reg         hyp_counting_disable;
  reg         trap_debug_rom_addr;
  reg         trap_debug_os_regs;
  reg         trap_debug_access;
  reg         trap_debug_exceptions;
  reg  [4:0]  el1_counter_count;

  wire        is_hyp;
  wire        is_kernel;
  wire        cfg_space;
  wire        sel_main;
  wire        sel_extra;
  wire        sel_dbg;
  wire        sel_any;
  wire        dbg_space;
  wire        cfg_trap;
  wire        cfg_denied;
  wire        dbg_trap;
  wire        setway_eff;
  wire        eff_rom;
  wire        eff_os;
  wire        eff_exc;
  wire        guest_level;
  wire        wr_ok;
  wire        wr_main;
  wire        wr_extra;
  wire        wr_dbg;
  wire        trap_any;
  reg  [31:0] main_rd;
  reg  [31:0] extra_rd;
  reg  [31:0] dbg_rd;
  reg  [31:0] next_rdata;

  function [19:0] htcr_pack;
    input [3:0] cp;
    input [2:0] o1;
    input [3:0] cn;
    input [3:0] cm;
    input [2:0] o2;
    input       wr;
    htcr_pack = {1'b0, wr, cp, o1, cn, cm, o2};
  endfunction

  // Register select: the shared encoding space plus one wanted opc2 value
  function htcr_hit;
    input       space;
    input [2:0] o2;
    input [2:0] want;
    htcr_hit = space && (o2 == want);
  endfunction

  assign is_hyp    = (i_priv_level == `HTCR_PL_HYP);
  assign is_kernel = (i_priv_level == `HTCR_PL_KERNEL);
  // The unused level code is handled like a guest, except that its debug register accesses never trap
  assign guest_level = !is_hyp;
  assign cfg_space = (i_coproc == `HTCR_COPROC_SYS) && (i_opc1 == `HTCR_OPC1_HYP)
                     && (i_crn == `HTCR_CRN_CFG) && (i_crm == `HTCR_CRM_CFG);
  assign sel_main  = htcr_hit(cfg_space, i_opc2, `HTCR_OPC2_MAIN);
  assign sel_extra = htcr_hit(cfg_space, i_opc2, `HTCR_OPC2_EXTRA);
  assign sel_dbg   = htcr_hit(cfg_space, i_opc2, `HTCR_OPC2_DBGCTL);
  assign sel_any   = sel_main || sel_extra || sel_dbg;
  assign dbg_space = (i_coproc == `HTCR_COPROC_DBG);

  // Kernel access with the group trap set goes to the hypervisor, not undefined
  assign cfg_trap   = sel_any && is_kernel && i_sysreg_trap_bit;
  assign cfg_denied = sel_any && !is_hyp && !cfg_trap;

  // Refused writes are cut here, so no field process needs the level check
  assign wr_ok    = i_sys_valid && i_sys_write && is_hyp;
  assign wr_main  = wr_ok && sel_main;
  assign wr_extra = wr_ok && sel_extra && (MIXCOH_RAZ == 0);
  assign wr_dbg   = wr_ok && sel_dbg;
  assign trap_any = cfg_trap || dbg_trap;

  assign setway_eff = (SETWAY_FIXED_ONE != 0) ? 1'b1 : setway_inval_override;

  // Effective values; direct reads return the stored bits, except the set/way bit, which reads setway_eff
  assign o_eff_fiq_mask_override = fiq_mask_override || trap_general_exceptions;
  assign o_eff_stage2_enable = stage2_protect_enable
                               || (default_cacheability && guest_level);
  assign eff_exc = trap_debug_exceptions || trap_general_exceptions;
  assign eff_rom = trap_debug_rom_addr || eff_exc;
  assign eff_os  = trap_debug_os_regs || eff_exc;
  assign o_route_debug_to_hyp = eff_exc && i_debug_exception && guest_level;
  assign o_mixcoh_noncoherent = mismatched_cacheability_noncoherence;

  assign o_convert_to_clean_inval = i_dcache_inval && is_kernel
    && ((i_dcache_setway && setway_eff) || o_eff_stage2_enable);

  htcr_debug_trap u_dbg_trap (
    .i_guest_access  (i_sys_valid && dbg_space),
    .i_priv_level    (i_priv_level),
    .i_dbg_class     (i_dbg_class),
    .i_comms_trapped (i_comms_trapped),
    .i_eff_rom       (eff_rom),
    .i_eff_os        (eff_os),
    .i_eff_acc       (trap_debug_access),
    .i_eff_exc       (eff_exc),
    .o_trap          (dbg_trap)
  );

  htcr_counter_gate #(
    .NUM_COUNTERS (NUM_COUNTERS)
  ) u_cnt_gate (
    .i_el1_counter_count                (el1_counter_count),
    .i_hyp_counting_disable             (hyp_counting_disable),
    .i_ext_counter_disable              (ext_debug_hyp_counter_disable),
    .i_in_hyp                           (is_hyp),
    .i_cycle_counter_disable_prohibited (i_cycle_counter_disable_prohibited),
    .i_hyp_noninv_debug_override        (i_hyp_noninv_debug_override),
    .o_count_enable                     (o_count_enable),
    .o_cycle_count_enable               (o_cycle_count_enable),
    .o_ext_access_enable                (o_ext_access_enable)
  );

  always @* begin
    main_rd                      = 32'h0;
    main_rd[`HTCR_MAIN_STAGE2]   = stage2_protect_enable;
    main_rd[`HTCR_MAIN_SETWAY]   = setway_eff;
    main_rd[`HTCR_MAIN_FIQMO]    = fiq_mask_override;
    main_rd[`HTCR_MAIN_DEFCACHE] = default_cacheability;
    main_rd[`HTCR_MAIN_TRAPGEN]  = trap_general_exceptions;
  end

  // Only the one bit is live; everything else reads zero
  always @* begin
    extra_rd                     = 32'h0;
    extra_rd[`HTCR_EXTRA_MIXCOH] = mismatched_cacheability_noncoherence;
  end

  always @* begin
    dbg_rd                                      = 32'h0;
    dbg_rd[`HTCR_DBG_CNT_MSB:`HTCR_DBG_CNT_LSB] = el1_counter_count;
    dbg_rd[`HTCR_DBG_TDEBEXC]                   = trap_debug_exceptions;
    dbg_rd[`HTCR_DBG_TDBGACC]                   = trap_debug_access;
    dbg_rd[`HTCR_DBG_TOSREGS]                   = trap_debug_os_regs;
    dbg_rd[`HTCR_DBG_TROMADR]                   = trap_debug_rom_addr;
    dbg_rd[`HTCR_DBG_HCNTDIS]                   = hyp_counting_disable;
    dbg_rd[`HTCR_DBG_EXTCDIS]                   = ext_debug_hyp_counter_disable;
  end

  always @* begin
    next_rdata = 32'h0;
    if (sel_main) begin
      next_rdata = main_rd;
    end else if (sel_extra) begin
      next_rdata = extra_rd;
    end else if (sel_dbg) begin
      next_rdata = dbg_rd;
    end
  end

  // Configuration registers: cold reset only
  always @(posedge i_clock) begin
    if (i_srst) begin
      fiq_mask_override       <= 1'b0;
      setway_inval_override   <= 1'b0;
      stage2_protect_enable   <= 1'b0;
      default_cacheability    <= 1'b0;
      trap_general_exceptions <= 1'b0;
    end else if (wr_main) begin
      fiq_mask_override       <= i_sys_wdata[`HTCR_MAIN_FIQMO];
      setway_inval_override   <= i_sys_wdata[`HTCR_MAIN_SETWAY];
      stage2_protect_enable   <= i_sys_wdata[`HTCR_MAIN_STAGE2];
      default_cacheability    <= i_sys_wdata[`HTCR_MAIN_DEFCACHE];
      trap_general_exceptions <= i_sys_wdata[`HTCR_MAIN_TRAPGEN];
    end
  end

  // Built read-as-zero, the bit is never written and stays at its reset zero
  always @(posedge i_clock) begin
    if (i_srst) begin
      mismatched_cacheability_noncoherence <= 1'b0;
    end else if (wr_extra) begin
      mismatched_cacheability_noncoherence <= i_sys_wdata[`HTCR_EXTRA_MIXCOH];
    end
  end

  // Debug control lives in the warm domain, so either reset clears the trap bits and reloads the count with COUNT_RESET
  always @(posedge i_clock) begin
    if (i_srst || i_warm_srst) begin
      ext_debug_hyp_counter_disable <= 1'b0;
      hyp_counting_disable          <= 1'b0;
      trap_debug_rom_addr           <= 1'b0;
      trap_debug_os_regs            <= 1'b0;
      trap_debug_access             <= 1'b0;
      trap_debug_exceptions         <= 1'b0;
      el1_counter_count             <= COUNT_RESET;
    end else if (wr_dbg) begin
      ext_debug_hyp_counter_disable <= i_sys_wdata[`HTCR_DBG_EXTCDIS];
      hyp_counting_disable          <= i_sys_wdata[`HTCR_DBG_HCNTDIS];
      trap_debug_rom_addr           <= i_sys_wdata[`HTCR_DBG_TROMADR];
      trap_debug_os_regs            <= i_sys_wdata[`HTCR_DBG_TOSREGS];
      trap_debug_access             <= i_sys_wdata[`HTCR_DBG_TDBGACC];
      trap_debug_exceptions         <= i_sys_wdata[`HTCR_DBG_TDEBEXC];
      // A count above the implemented total leaves every counter with the guest
      el1_counter_count <= i_sys_wdata[`HTCR_DBG_CNT_MSB:`HTCR_DBG_CNT_LSB];
    end
  end

  // Answer one cycle after the request; trapped accesses change no register field, only the syndrome
  always @(posedge i_clock) begin
    if (i_srst) begin
      o_sys_rdata <= 32'h0;
      o_sys_done  <= 1'b0;
      o_trap      <= 1'b0;
      o_undef     <= 1'b0;
    end else begin
      o_sys_done <= i_sys_valid;
      o_trap     <= i_sys_valid && trap_any;
      o_undef    <= i_sys_valid && cfg_denied;
      if (i_sys_valid) begin
        o_sys_rdata <= (!i_sys_write && is_hyp) ? next_rdata : 32'h0;
      end
    end
  end

  // Syndrome stands until the next trapped access overwrites it; a refused access rewrites only the class
  always @(posedge i_clock) begin
    if (i_srst) begin
      o_syndrome_class <= `HTCR_SYN_NONE;
      o_syndrome_info  <= 20'h0;
    end else if (i_sys_valid && trap_any) begin
      o_syndrome_class <= cfg_trap ? `HTCR_SYN_CFGREG : `HTCR_SYN_DEBUG;
      o_syndrome_info  <= htcr_pack(i_coproc, i_opc1, i_crn, i_crm, i_opc2,
                                    i_sys_write);
    end else if (i_sys_valid && cfg_denied) begin
      o_syndrome_class <= `HTCR_SYN_DENIED;
    end
  end
endmodule

// file: sim/htcr_regs_properties.sv
`timescale 1ns/1ns
`include "htcr_defs.vh"
module htcr_checker #(
  parameter NUM_COUNTERS = 31
) (
  input logic                    i_clock,
  input logic                    i_srst,
  input logic                    i_warm_srst,
  input logic                    i_sys_valid,
  input logic                    i_sys_write,
  input logic [3:0]              i_coproc,
  input logic [2:0]              i_opc1,
  input logic [3:0]              i_crn,
  input logic [3:0]              i_crm,
  input logic [2:0]              i_opc2,
  input logic [31:0]             i_sys_wdata,
  input logic [1:0]              i_priv_level,
  input logic                    i_sysreg_trap_bit,
  input logic                    i_dcache_inval,
  input logic [31:0]             o_sys_rdata,
  input logic                    o_sys_done,
  input logic                    o_trap,
  input logic                    o_undef,
  input logic [1:0]              o_syndrome_class,
  input logic                    o_eff_fiq_mask_override,
  input logic                    o_eff_stage2_enable,
  input logic                    o_convert_to_clean_inval,
  input logic [NUM_COUNTERS-1:0] o_count_enable
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  // Encoding f/4/1/1; opc2 picks main, debug control or extra register
  wire cfg = {i_coproc, i_opc1, i_crn, i_crm} == 15'h7c11 && i_opc2 inside {3'h0, 3'h1, 3'h4};
  wire acc = i_sys_valid && cfg;
  wire hyp = i_priv_level == `HTCR_PL_HYP;
  wire knl = i_priv_level == `HTCR_PL_KERNEL;
  sequence s_hyp_wr(o2);
    acc && hyp && i_sys_write && i_opc2 == o2;
  endsequence
  sequence s_extra_rd;
    acc && hyp && !i_sys_write && i_opc2 == 3'h4;
  endsequence
  a_done_pulse: assert property (i_sys_valid |=> o_sys_done)
    else $error("access without done");
  a_user_denied: assert property (acc && i_priv_level == `HTCR_PL_USER |=> o_undef && !o_trap)
    else $error("user access not refused");
  a_kernel_denied: assert property (acc && knl && !i_sysreg_trap_bit |=> o_undef && !o_trap)
    else $error("kernel access not refused");
  a_kernel_trapped: assert property (acc && knl && i_sysreg_trap_bit
    |=> o_trap && o_syndrome_class == `HTCR_SYN_CFGREG)
    else $error("kernel access not trapped");
  a_trap_no_data: assert property (o_trap |-> o_sys_rdata == 32'h0)
    else $error("trapped access returned data");
  a_fiq_forced: assert property (s_hyp_wr(3'h0) ##0 i_sys_wdata[27]
    |=> o_eff_fiq_mask_override)
    else $error("fiq override not forced");
  a_stage2_clean: assert property (o_eff_stage2_enable && knl && i_dcache_inval
    |-> o_convert_to_clean_inval)
    else $error("invalidate not converted");
  a_extra_reserved: assert property (s_extra_rd
    |=> o_sys_rdata[31:7] == 25'h0 && o_sys_rdata[5:0] == 6'h0)
    else $error("reserved extra bits nonzero");
  a_hyp_count_off: assert property (disable iff (i_srst || i_warm_srst)
    s_hyp_wr(3'h1) ##0 i_sys_wdata[17] && i_sys_wdata[4:0] == 5'h3 ##1 hyp
    |-> o_count_enable[2:0] == 3'h0)
    else $error("guest counters run in hyp");
endmodule
bind htcr_regs htcr_checker #(.NUM_COUNTERS(NUM_COUNTERS)) u_chk (.*);

// file: sim/test_htcr_regs.sv
`timescale 1ns/1ns
`include "htcr_defs.vh"
module test_htcr_regs;
  localparam logic [3:0] SYS = `HTCR_COPROC_SYS;
  localparam logic [1:0] HYP = `HTCR_PL_HYP;
  logic        i_clock = 1'h0, i_srst = 1'h1, i_warm_srst = 1'h0, i_sys_valid = 1'h0;
  logic        i_sys_write = 1'h0, i_sysreg_trap_bit = 1'h0, i_comms_trapped = 1'h0;
  logic        i_dcache_inval = 1'h0, i_dcache_setway = 1'h0, i_debug_exception = 1'h0;
  logic        dp = 1'h0, ovr = 1'h0, g, s2x;
  logic [3:0]  i_coproc = 4'h0, i_crn = 4'h1, i_crm = 4'h1;
  logic [2:0]  i_opc1 = 3'h4, i_opc2 = 3'h0;
  logic [2:0]  regsel [3] = '{3'h0, 3'h4, 3'h1};
  logic [1:0]  i_priv_level = 2'h0, i_dbg_class = 2'h0, o_syndrome_class, pl;
  logic [31:0] i_sys_wdata = 32'h0, o_sys_rdata, d, m;
  logic [19:0] o_syndrome_info;
  logic [7:0]  cnt_en, ext_en;
  logic        o_sys_done, o_trap, o_undef, fiq, s2, cvt, mix, route, cyc;
  int          error_cnt = 0, n_compared = 0, k;

  htcr_regs #(.NUM_COUNTERS(8)) u_dut (.*, .o_eff_fiq_mask_override(fiq),
    .o_eff_stage2_enable(s2), .o_convert_to_clean_inval(cvt), .o_mixcoh_noncoherent(mix),
    .o_route_debug_to_hyp(route), .o_count_enable(cnt_en), .o_cycle_count_enable(cyc),
    .o_ext_access_enable(ext_en), .i_cycle_counter_disable_prohibited(dp),
    .i_hyp_noninv_debug_override(ovr));

  initial forever #25 i_clock = ~i_clock;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    if (error_cnt == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Leaves valid high so back-to-back calls need no idle cycle
  task automatic acc(input logic wr, input logic [3:0] cp, input logic [2:0] o2,
                     input logic [31:0] wd, input logic [1:0] p);
    {i_sys_valid, i_sys_write, i_coproc, i_opc2, i_sys_wdata, i_priv_level} = {1'h1, wr, cp, o2, wd, p};
    @(negedge i_clock);
    check(o_sys_done, 1'h1);
  endtask

  // Only the fields this block owns are stored; the rest read zero
  function automatic logic [31:0] keep(input logic [2:0] o2, input logic [31:0] wd);
    case (o2)
      3'h0: return wd & 32'h0800100b;
      3'h4: return wd & 32'h00000040;
      default: return wd & 32'h00220f1f;
    endcase
  endfunction

  function automatic logic dtrap(input logic [31:0] dv, input logic ge, input logic [1:0] c,
                                 input logic cm, input logic [1:0] p);
    // OS-lock and powerdown traps take no exemption from the comms-channel trap
    if (c == 2'h2 && p == 2'h1 && (dv[10] | dv[8] | ge)) return 1'h1;
    if (cm) return 1'h0;
    if (dv[8] | ge) return 1'h1;
    case (c)
      2'h1: return dv[11];
      2'h2: return dv[10] & (p == 2'h1);
      default: return dv[9];
    endcase
  endfunction

  initial begin
    #100000;
    error_cnt++;
    stop_test();
  end

  initial begin
    void'($urandom(32'h0108));
    repeat (12) @(negedge i_clock);
    i_srst = 1'h0;
    @(negedge i_clock);
    for (k = 0; k < 3; k++) begin
      acc(1'h0, SYS, regsel[k], 32'h0, HYP);
      check(o_sys_rdata, k == 2 ? 32'h1f : 32'h0);
    end
    repeat (24) begin
      k = $urandom_range(2);
      d = $urandom;
      acc(1'h1, SYS, regsel[k], d, HYP);
      acc(1'h0, SYS, regsel[k], 32'h0, HYP);
      check(o_sys_rdata, keep(regsel[k], d));
      if (k == 1) check(mix, d[6]);
    end
    acc(1'h0, SYS, 3'h3, 32'h0, HYP);
    check(o_sys_rdata, 32'h0);
    acc(1'h1, SYS, 3'h0, 32'h8, HYP);
    for (k = 0; k < 4; k++) begin
      i_sysreg_trap_bit = k[1];
      acc(1'h1, SYS, 3'h0, 32'h1, {1'h0, k[0]});
      check({o_trap, o_undef}, k == 3 ? 2'h2 : 2'h1);
      if (k == 3) check(o_syndrome_info, {9'h0fc, 4'h1, 4'h1, 3'h0});
    end
    i_sysreg_trap_bit = 1'h0;
    acc(1'h0, SYS, 3'h0, 32'h0, HYP);
    check(o_sys_rdata, 32'h8);
    repeat (40) begin
      m = $urandom & 32'h0800100b;
      acc(1'h1, SYS, 3'h0, m, HYP);
      {i_sys_valid, i_dcache_inval, i_dcache_setway} = {1'h0, 2'($urandom)};
      i_priv_level = 2'($urandom_range(2));
      s2x = m[0] | (m[12] & i_priv_level != HYP);
      #1;
      check(fiq, m[3] | m[27]);
      check(s2, s2x);
      check(cvt, i_dcache_inval & i_priv_level == 2'h1 & (s2x | i_dcache_setway & m[1]));
      @(negedge i_clock);
    end
    repeat (40) begin
      d = $urandom & 32'h0f00;
      g = 1'($urandom);
      acc(1'h1, SYS, 3'h1, d, HYP);
      acc(1'h1, SYS, 3'h0, {4'h0, g, 27'h0}, HYP);
      {i_dbg_class, i_comms_trapped, i_debug_exception} = {2'($urandom_range(2)), 1'($urandom), 1'h1};
      pl = 2'($urandom_range(1));
      acc(1'h0, `HTCR_COPROC_DBG, 3'h0, 32'h0, pl);
      check(o_trap, dtrap(d, g, i_dbg_class, i_comms_trapped, pl));
      check(route, d[8] | g);
    end
    acc(1'h1, SYS, 3'h1, 32'h00220003, HYP);
    {i_sys_valid, dp} = 2'h1;
    #1;
    check(cnt_en[2:0], 3'h0);
    check(cyc, 1'h0);
    check(ext_en, 8'h07);
    @(negedge i_clock);
    {ovr, i_priv_level} = 3'h5;
    #1;
    check(ext_en, 8'hff);
    check(cnt_en[2:0], 3'h7);
    @(negedge i_clock);
    acc(1'h1, SYS, 3'h0, 32'h8, HYP);
    i_warm_srst = 1'h1;
    @(negedge i_clock);
    i_warm_srst = 1'h0;
    acc(1'h0, SYS, 3'h1, 32'h0, HYP);
    check(o_sys_rdata, 32'h1f);
    acc(1'h0, SYS, 3'h0, 32'h0, HYP);
    check(o_sys_rdata, 32'h8);
    {i_srst, i_sys_valid} = 2'h2;
    repeat (2) @(negedge i_clock);
    i_srst = 1'h0;
    @(negedge i_clock);
    acc(1'h0, SYS, 3'h0, 32'h0, HYP);
    check(o_sys_rdata, 32'h0);
    stop_test();
  end
endmodule
